// *** lce_pkg.sv ***
// Shared types and constants for the ladder coil and edge evaluator
package lce_pkg;

	// ----------------------------------------------------------------
	// Field widths and number formats
	// ----------------------------------------------------------------
	localparam int LCE_ADDR_W  = 8;
	localparam int LCE_BCD_W   = 8;
	localparam int LCE_CNT_W   = 8;
	localparam int LCE_WORD_W  = 16;
	localparam int LCE_BIT_W   = 4;
	localparam int LCE_DIGIT_W = 4;

	localparam logic [4:0] LCE_BIT_MAX   = 5'h0f;
	localparam logic [3:0] LCE_DIGIT_MAX = 4'h9;
	localparam logic [3:0] LCE_TENS_MAX  = 4'h1;
	localparam logic [4:0] LCE_BCD_RADIX = 5'h0a;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic LCE_ACC_RST = 1'b0;
	localparam logic LCE_HIST_RST = 1'b0;
	localparam logic [LCE_WORD_W-1:0] LCE_WORD_RST = 16'h0000;

	// ----------------------------------------------------------------
	// Instruction set handled here
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		LCE_OP_NOP,
		LCE_OP_OR_COIL,
		LCE_OP_BIT_COIL,
		LCE_OP_INVERT,
		LCE_OP_RISE_PULSE_COIL,
		LCE_OP_RISE_START_CONTACT,
		LCE_OP_FALL_START_CONTACT,
		LCE_OP_RISE_PARALLEL_CONTACT,
		LCE_OP_FALL_PARALLEL_CONTACT,
		LCE_OP_RISE_SERIES_CONTACT,
		LCE_OP_FALL_SERIES_CONTACT,
		LCE_OP_SET,
		LCE_OP_RESET
	} lce_op_e;

	typedef struct packed {
		lce_op_e               op;      // Instruction
		logic [LCE_ADDR_W-1:0] addr;    // Point index, or word index for bit_coil
		logic [LCE_BCD_W-1:0]  bit_bcd; // Bit index in BCD
		logic [LCE_CNT_W-1:0]  cnt;     // Range length for set/reset, 0 means 1
	} lce_instr_s;

endpackage

// *** lce_edge_mem.sv ***
// Per-instruction edge history: previous-scan value for each program position
`timescale 1ns/1ps
module lce_edge_mem
	import lce_pkg::*;
#(
	parameter int DEPTH = 256
) (
	input  wire logic                     clk_sys, // System clock
	input  wire logic                     rst,     // Async reset, active high
	input  wire logic [$clog2(DEPTH)-1:0] idx,     // Program position
	input  wire logic                     wr_en,   // Store value for this position
	input  wire logic                     wr_val,  // Value seen this scan
	output      logic                     prev     // Value stored last scan
);

	logic [DEPTH-1:0] hist_reg;

	if (DEPTH < 2) begin : g_bad_depth
		$error("lce_edge_mem: DEPTH must be at least 2");
	end

	assign prev = hist_reg[idx];

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			hist_reg <= {DEPTH{LCE_HIST_RST}};
		end else if (wr_en) begin
			hist_reg[idx] <= wr_val; // see [RQ14]
		end
	end

endmodule

// *** lce_word_mem.sv ***
// Data words with single-bit write and one read port
`timescale 1ns/1ps
module lce_word_mem
	import lce_pkg::*;
#(
	parameter int NWORDS = 16
) (
	input  wire logic                      clk_sys, // System clock
	input  wire logic                      rst,     // Async reset, active high
	input  wire logic                      wr_en,   // Write one bit
	input  wire logic [$clog2(NWORDS)-1:0] wr_word, // Word to write
	input  wire logic [LCE_BIT_W-1:0]      wr_bit,  // Bit within word
	input  wire logic                      wr_val,  // Bit value
	input  wire logic [$clog2(NWORDS)-1:0] rd_word, // Word to read
	output      logic [LCE_WORD_W-1:0]     rd_data  // Read data
);

	logic [LCE_WORD_W-1:0] mem_reg [NWORDS];

	if (NWORDS < 2) begin : g_bad_words
		$error("lce_word_mem: NWORDS must be at least 2");
	end

	assign rd_data = mem_reg[rd_word];

	// Later writes in a scan overwrite earlier ones, so program order decides
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NWORDS; i++) begin
				mem_reg[i] <= LCE_WORD_RST;
			end
		end else if (wr_en) begin
			mem_reg[wr_word][wr_bit] <= wr_val; // see [RQ2] see [RQ3]
		end
	end

	// Every write must land, so the last one in a scan is what remains
	bit_lands_a: assert property ( // see [RQ3]
		@(posedge clk_sys) disable iff (rst)
		wr_en |=> mem_reg[$past(wr_word)][$past(wr_bit)] == $past(wr_val))
		else $error("bit write did not land");

endmodule

// *** lce_ladder_coil_edge_eval.sv ***
// Ladder instruction evaluator: or-coil, bit coil, invert, edge coils/contacts, set/reset
//
// Functional notes
// [RQ1] Several or-coils on one output: on if any rung on, off if all off.
// [RQ2] Bit coil copies rung status into one word bit; BCD index 0 to 15.
// [RQ3] Repeated bit coils on one bit: last rung in program order wins.
// [RQ4] Invert replaces rung status with its complement for later elements.
// [RQ5] Rising pulse coil drives target on one scan per rung off-to-on.
// [RQ6] Rising start contact begins rung; closed one scan after point rises.
// [RQ7] Falling start contact begins rung; closed one scan after point falls.
// [RQ8] Rising parallel contact ORs in a one-scan closure on point rise.
// [RQ9] Falling parallel contact ORs in a one-scan closure on point fall.
// [RQ10] Falling series contact ANDs in closure only the scan after a fall.
// [RQ11] Rising series contact passes one scan when rung on and point rose.
// [RQ12] Set turns on a point or range while rung on; points stay on.
// [RQ13] Reset turns off a point or range while rung on; points stay off.
// [RQ14] Edges compare with the value stored at the same position last scan.
`timescale 1ns/1ps
module lce_ladder_coil_edge_eval
	import lce_pkg::*;
#(
	parameter int NPOINTS = 64,  // Image register points
	parameter int NIN     = 8,   // Low points refreshed from input pins
	parameter int NWORDS  = 16,  // Data words
	parameter int NINSTR  = 256  // Program positions with edge history
) (
	input  wire logic                  clk_sys,     // 200 MHz system clock
	input  wire logic                  rst,         // Async reset, active high
	input  wire logic                  scan_start,  // Pulse: new program scan
	input  wire logic                  instr_valid, // Instruction present
	input  wire lce_instr_s            instr,       // Instruction and operands
	input  wire logic [NIN-1:0]        in_pins,     // Asynchronous input pins
	input  wire logic [LCE_ADDR_W-1:0] word_sel,    // Word to show on word_q
	output      logic                  instr_ack,   // Pulse: instruction executed
	output      logic                  rung_q,      // Current rung status
	output      logic [NPOINTS-1:0]    points_q,    // Image register
	output      logic [LCE_WORD_W-1:0] word_q,      // Selected data word
	output      logic                  bcd_err_q    // Pulse: bad bit index ignored
);

	localparam int PAW = $clog2(NPOINTS);
	localparam int WAW = $clog2(NWORDS);
	localparam int IAW = $clog2(NINSTR);

	if (NPOINTS < 2 || NPOINTS > (1 << LCE_ADDR_W)) begin : g_bad_points
		$error("NPOINTS out of range");
	end
	if (NIN < 1 || NIN >= NPOINTS) begin : g_bad_nin
		$error("NIN must be below NPOINTS");
	end
	if (NWORDS < 2 || NWORDS > (1 << LCE_ADDR_W)) begin : g_bad_words
		$error("NWORDS out of range");
	end
	if (NINSTR < 2) begin : g_bad_instr
		$error("NINSTR must be at least 2");
	end

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	function automatic logic bcd_ok(input logic [LCE_BCD_W-1:0] b);
		logic [4:0] v;
		v = 5'(b[LCE_BCD_W-1:LCE_DIGIT_W]) * LCE_BCD_RADIX + 5'(b[LCE_DIGIT_W-1:0]);
		return (b[LCE_BCD_W-1:LCE_DIGIT_W] <= LCE_TENS_MAX) &&
		       (b[LCE_DIGIT_W-1:0] <= LCE_DIGIT_MAX) && (v <= LCE_BIT_MAX);
	endfunction

	function automatic logic [LCE_BIT_W-1:0] bcd_bin(input logic [LCE_BCD_W-1:0] b);
		logic [4:0] v;
		v = 5'(b[LCE_BCD_W-1:LCE_DIGIT_W]) * LCE_BCD_RADIX + 5'(b[LCE_DIGIT_W-1:0]);
		return v[LCE_BIT_W-1:0];
	endfunction

	// Points base .. base+n-1, n of zero taken as one; clipped at the top
	function automatic logic [NPOINTS-1:0] range_mask(input logic [LCE_ADDR_W-1:0] base,
	                                                  input logic [LCE_CNT_W-1:0] n);
		logic [NPOINTS-1:0] m;
		int                 last;
		m = '0;
		last = int'(base) + ((n == '0) ? 1 : int'(n));
		for (int i = 0; i < NPOINTS; i++) begin
			m[i] = (i >= int'(base)) && (i < last);
		end
		return m;
	endfunction

	// ----------------------------------------------------------------
	// Input pin synchroniser
	// ----------------------------------------------------------------
	logic [NIN-1:0] pins_meta_reg;
	logic [NIN-1:0] pins_sync_reg;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pins_meta_reg <= '0;
			pins_sync_reg <= '0;
		end else begin
			pins_meta_reg <= in_pins;
			pins_sync_reg <= pins_meta_reg;
		end
	end

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	logic               acc_reg;
	logic [NPOINTS-1:0] points_reg;
	logic [NPOINTS-1:0] or_acc_reg;
	logic [IAW-1:0]     pc_reg;
	logic [LCE_WORD_W-1:0] word_reg;
	logic               ack_reg;
	logic               bcd_err_reg;

	// Scan start wins; an instruction in that cycle is dropped, ack stays low
	wire       exec     = instr_valid && !scan_start;
	wire lce_op_e op    = instr.op;
	wire       addr_ok  = {1'b0, instr.addr} < (LCE_ADDR_W+1)'(NPOINTS);
	wire [PAW-1:0] pidx = instr.addr[PAW-1:0];
	wire       pt       = addr_ok && points_reg[pidx];
	wire       word_ok  = {1'b0, instr.addr} < (LCE_ADDR_W+1)'(NWORDS);
	wire       idx_ok   = bcd_ok(instr.bit_bcd);

	wire is_start   = (op == LCE_OP_RISE_START_CONTACT) || (op == LCE_OP_FALL_START_CONTACT);
	wire is_par     = (op == LCE_OP_RISE_PARALLEL_CONTACT) ||
	                  (op == LCE_OP_FALL_PARALLEL_CONTACT);
	wire is_ser     = (op == LCE_OP_RISE_SERIES_CONTACT) || (op == LCE_OP_FALL_SERIES_CONTACT);
	wire is_contact = is_start || is_par || is_ser;
	wire is_fall    = (op == LCE_OP_FALL_START_CONTACT) ||
	                  (op == LCE_OP_FALL_PARALLEL_CONTACT) ||
	                  (op == LCE_OP_FALL_SERIES_CONTACT);
	wire is_edge    = is_contact || (op == LCE_OP_RISE_PULSE_COIL);

	// Contacts watch their point, the pulse coil watches its rung input
	wire prev;
	wire edge_src = is_contact ? pt : acc_reg;
	wire edge_hit = is_fall ? (!edge_src && prev) : (edge_src && !prev); // see [RQ14]

	lce_edge_mem #(
		.DEPTH (NINSTR)
	) u_edge (
		.clk_sys (clk_sys),
		.rst     (rst),
		.idx     (pc_reg),
		.wr_en   (exec && is_edge),
		.wr_val  (edge_src),
		.prev    (prev)
	);

	// ----------------------------------------------------------------
	// Rung status
	// ----------------------------------------------------------------
	wire acc_next =
		!exec                  ? acc_reg :
		(op == LCE_OP_INVERT)  ? !acc_reg :            // see [RQ4]
		is_start               ? edge_hit :            // see [RQ6] see [RQ7]
		is_par                 ? (acc_reg || edge_hit) : // see [RQ8] see [RQ9]
		is_ser                 ? (acc_reg && edge_hit) : // see [RQ10] see [RQ11]
		acc_reg;

	// ----------------------------------------------------------------
	// Image register
	// ----------------------------------------------------------------
	wire [NPOINTS-1:0] sel_mask = addr_ok ? (NPOINTS'(1) << pidx) : '0;
	wire [NPOINTS-1:0] rng_mask = range_mask(instr.addr, instr.cnt);
	wire is_coil  = (op == LCE_OP_OR_COIL) || (op == LCE_OP_RISE_PULSE_COIL);
	wire coil_val = (op == LCE_OP_OR_COIL) ? (or_acc_reg[pidx] || acc_reg) // see [RQ1]
	                                       : edge_hit;                     // see [RQ5]

	wire [NPOINTS-1:0] points_next =
		scan_start ? {points_reg[NPOINTS-1:NIN], pins_sync_reg} :
		!exec      ? points_reg :
		is_coil    ? ((points_reg & ~sel_mask) | (sel_mask & {NPOINTS{coil_val}})) :
		(op == LCE_OP_SET && acc_reg)   ? (points_reg | rng_mask) :  // see [RQ12]
		(op == LCE_OP_RESET && acc_reg) ? (points_reg & ~rng_mask) : // see [RQ13]
		points_reg;

	// Or-coil collector restarts each scan so an output can drop again
	wire [NPOINTS-1:0] or_acc_next =
		scan_start ? '0 :
		(exec && op == LCE_OP_OR_COIL && acc_reg) ? (or_acc_reg | sel_mask) : // see [RQ1]
		or_acc_reg;

	// ----------------------------------------------------------------
	// Data words
	// ----------------------------------------------------------------
	wire bit_wr = exec && (op == LCE_OP_BIT_COIL) && idx_ok && word_ok;
	wire [LCE_WORD_W-1:0] word_rd;

	lce_word_mem #(
		.NWORDS (NWORDS)
	) u_words (
		.clk_sys (clk_sys),
		.rst     (rst),
		.wr_en   (bit_wr),
		.wr_word (instr.addr[WAW-1:0]),
		.wr_bit  (bcd_bin(instr.bit_bcd)),
		.wr_val  (acc_reg),               // see [RQ2]
		.rd_word (word_sel[WAW-1:0]),
		.rd_data (word_rd)
	);

	wire word_sel_ok = {1'b0, word_sel} < (LCE_ADDR_W+1)'(NWORDS);
	wire bad_idx     = exec && (op == LCE_OP_BIT_COIL) && !idx_ok;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			acc_reg     <= LCE_ACC_RST;
			points_reg  <= '0;
			or_acc_reg  <= '0;
			pc_reg      <= '0;
			word_reg    <= LCE_WORD_RST;
			ack_reg     <= 1'b0;
			bcd_err_reg <= 1'b0;
		end else begin
			acc_reg     <= acc_next;
			points_reg  <= points_next;
			or_acc_reg  <= or_acc_next;
			pc_reg      <= scan_start ? '0 : (exec ? pc_reg + 1'b1 : pc_reg); // see [RQ14]
			word_reg    <= word_sel_ok ? word_rd : LCE_WORD_RST;
			ack_reg     <= exec;
			bcd_err_reg <= bad_idx;
		end
	end

	assign instr_ack = ack_reg;
	assign rung_q    = acc_reg;
	assign points_q  = points_reg;
	assign word_q    = word_reg;
	assign bcd_err_q = bcd_err_reg;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	or_coil_on_a: assert property ( // see [RQ1]
		exec && op == LCE_OP_OR_COIL && addr_ok && (acc_reg || or_acc_reg[pidx])
		|=> points_reg[$past(pidx)])
		else $error("or-coil output not on with a rung on");

	or_coil_off_a: assert property ( // see [RQ1]
		exec && op == LCE_OP_OR_COIL && addr_ok && !acc_reg && !or_acc_reg[pidx]
		|=> !points_reg[$past(pidx)])
		else $error("or-coil output on with all rungs off");

	bcd_reject_a: assert property ( // see [RQ2]
		exec && op == LCE_OP_BIT_COIL && !idx_ok |=> bcd_err_q && !$past(bit_wr))
		else $error("bad bit index not rejected");

	invert_rung_a: assert property ( // see [RQ4]
		exec && op == LCE_OP_INVERT |=> acc_reg != $past(acc_reg))
		else $error("invert did not complement rung");

	rise_coil_a: assert property ( // see [RQ5]
		exec && op == LCE_OP_RISE_PULSE_COIL && addr_ok
		|=> points_reg[$past(pidx)] == ($past(acc_reg) && !$past(prev)))
		else $error("rising pulse coil wrong");

	start_contact_a: assert property ( // see [RQ6]
		exec && op == LCE_OP_RISE_START_CONTACT |=> acc_reg == ($past(pt) && !$past(prev)))
		else $error("rising start contact wrong");

	fall_start_a: assert property ( // see [RQ7]
		exec && op == LCE_OP_FALL_START_CONTACT |=> acc_reg == (!$past(pt) && $past(prev)))
		else $error("falling start contact wrong");

	rise_parallel_a: assert property ( // see [RQ8]
		exec && op == LCE_OP_RISE_PARALLEL_CONTACT
		|=> acc_reg == ($past(acc_reg) || ($past(pt) && !$past(prev))))
		else $error("rising parallel contact wrong");

	fall_parallel_a: assert property ( // see [RQ9]
		exec && op == LCE_OP_FALL_PARALLEL_CONTACT
		|=> acc_reg == ($past(acc_reg) || (!$past(pt) && $past(prev))))
		else $error("falling parallel contact wrong");

	fall_series_a: assert property ( // see [RQ10]
		exec && op == LCE_OP_FALL_SERIES_CONTACT
		|=> acc_reg == ($past(acc_reg) && !$past(pt) && $past(prev)))
		else $error("falling series contact wrong");

	rise_series_a: assert property ( // see [RQ11]
		exec && op == LCE_OP_RISE_SERIES_CONTACT
		|=> acc_reg == ($past(acc_reg) && $past(pt) && !$past(prev)))
		else $error("rising series contact wrong");

	set_range_a: assert property ( // see [RQ12]
		exec && op == LCE_OP_SET && acc_reg |=> (points_reg & $past(rng_mask)) == $past(rng_mask))
		else $error("set range not on");

	reset_range_a: assert property ( // see [RQ13]
		exec && op == LCE_OP_RESET && acc_reg |=> (points_reg & $past(rng_mask)) == '0)
		else $error("reset range not off");

	pc_step_a: assert property ( // see [RQ14]
		exec |=> pc_reg == IAW'($past(pc_reg) + 1'b1))
		else $error("program position did not advance");

endmodule

// *** test_ladder_coil_edge_eval.sv ***
// Self-checking bench for the ladder coil and edge evaluator
`timescale 1ns/1ps
module test_ladder_coil_edge_eval
	import lce_pkg::*;
;
	typedef struct packed {
		logic        rung;
		logic [63:0] pts;
		logic        err;
	} lce_tb_exp_s;

	logic                  clk_sys;
	logic                  rst;
	logic                  scan_start;
	logic                  instr_valid;
	lce_instr_s            instr;
	logic [7:0]            in_pins;
	logic [LCE_ADDR_W-1:0] word_sel;
	logic                  instr_ack;
	logic                  rung_q;
	logic [63:0]           points_q;
	logic [LCE_WORD_W-1:0] word_q;
	logic                  bcd_err_q;
	lce_tb_exp_s           exp_q[$];
	lce_tb_exp_s           mon_ex;
	lce_instr_s            prog[21];
	logic [63:0]           m_pts;
	logic [63:0]           m_orc;
	logic [15:0]           m_words[16];
	logic                  m_hist[256];
	logic                  m_acc;
	logic [31:0]           lfsr;
	int                    pc;
	int                    mismatches = 0;
	int                    n_compared = 0;
	int                    cycles     = 0;

	lce_ladder_coil_edge_eval #(.NPOINTS(64), .NIN(8), .NWORDS(16), .NINSTR(256)) dut (
		.clk_sys    (clk_sys),
		.rst        (rst),
		.scan_start (scan_start),
		.instr_valid(instr_valid),
		.instr      (instr),
		.in_pins    (in_pins),
		.word_sel   (word_sel),
		.instr_ack  (instr_ack),
		.rung_q     (rung_q),
		.points_q   (points_q),
		.word_q     (word_q),
		.bcd_err_q  (bcd_err_q)
	);

	// ----------------------------------------------------------------
	// Helpers and reference model
	// ----------------------------------------------------------------
	function automatic logic [31:0] lfsr_next(input logic [31:0] x);
		return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h00000000);
	endfunction

	function automatic lce_instr_s mk(input lce_op_e op, input logic [7:0] a,
		input logic [7:0] b, input logic [7:0] c);
		return '{op, a, b, c};
	endfunction

	task automatic cmp_bit(input string what, input logic e, input logic g);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s: expected %b seen %b", what, e, g);
		end
	endtask

	task automatic cmp_vec(input string what, input logic [63:0] e, input logic [63:0] g);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", what, e, g);
		end
	endtask

	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic exec(input lce_instr_s i);
		logic p;
		logic e;
		logic err;
		int   n;
		int   b;
		p = m_pts[i.addr[5:0]] & (i.addr < 8'h40);
		// Edge against this position's value last scan
		if (i.op inside {LCE_OP_RISE_START_CONTACT, LCE_OP_RISE_PARALLEL_CONTACT,
			LCE_OP_RISE_SERIES_CONTACT}) begin
			e = p & !m_hist[pc];
		end else begin
			e = !p & m_hist[pc];
		end
		n = (i.cnt == 8'h00) ? 1 : int'(i.cnt);
		b = int'(i.bit_bcd[7:4]) * 10 + int'(i.bit_bcd[3:0]);
		err = 1'b0;
		case (i.op)
			LCE_OP_INVERT: m_acc = !m_acc;
			LCE_OP_RISE_START_CONTACT, LCE_OP_FALL_START_CONTACT: m_acc = e;
			LCE_OP_RISE_PARALLEL_CONTACT,
			LCE_OP_FALL_PARALLEL_CONTACT: m_acc = m_acc | e;
			LCE_OP_RISE_SERIES_CONTACT,
			LCE_OP_FALL_SERIES_CONTACT: m_acc = m_acc & e;
			LCE_OP_OR_COIL: begin
				m_orc[i.addr[5:0]] = m_orc[i.addr[5:0]] | m_acc;
				m_pts[i.addr[5:0]] = m_orc[i.addr[5:0]];
			end
			LCE_OP_RISE_PULSE_COIL: m_pts[i.addr[5:0]] = m_acc & !m_hist[pc];
			LCE_OP_SET, LCE_OP_RESET: begin
				for (int k = 0; k < n; k++) begin
					if (m_acc && int'(i.addr) + k < 64) begin
						m_pts[int'(i.addr) + k] = (i.op == LCE_OP_SET);
					end
				end
			end
			LCE_OP_BIT_COIL: begin
				err = !(i.bit_bcd[3:0] <= 4'h9 && i.bit_bcd[7:4] <= 4'h1 && b <= 15);
				if (!err) begin
					m_words[i.addr[3:0]][b] = m_acc;
				end
			end
			default: ;
		endcase
		m_hist[pc] = (i.op == LCE_OP_RISE_PULSE_COIL) ? m_acc : p;
		exp_q.push_back('{m_acc, m_pts, err});
		pc++;
	endtask

	// ----------------------------------------------------------------
	// Stimulus
	// ----------------------------------------------------------------
	task automatic do_reset();
		@(negedge clk_sys);
		rst = 1'b1;
		repeat (20) @(negedge clk_sys);
		rst = 1'b0;
		m_pts = '0;
		m_orc = '0;
		foreach (m_words[k]) m_words[k] = 16'h0000;
		foreach (m_hist[k]) m_hist[k] = 1'b0;
		m_acc = 1'b0;
		pc = 0;
		exp_q.delete();
	endtask

	task automatic run_scan(input int s);
		lce_instr_s i;
		in_pins = lfsr[7:0];
		lfsr = lfsr_next(lfsr);
		repeat (3) @(negedge clk_sys);
		scan_start = 1'b1;
		// Offered with scan_start high, so it must be dropped
		instr_valid = 1'b1;
		instr = prog[14];
		m_pts[7:0] = in_pins;
		m_orc = '0;
		pc = 0;
		@(negedge clk_sys);
		scan_start = 1'b0;
		foreach (prog[k]) begin
			i = prog[k];
			if (i.bit_bcd == 8'hff) begin
				i.bit_bcd = 8'((s % 16) / 10 * 16 + (s % 16) % 10);
			end
			instr = i;
			exec(i);
			@(negedge clk_sys);
		end
		instr_valid = 1'b0;
		repeat (3) @(negedge clk_sys);
		cmp_vec("word_q", {48'h0, m_words[3]}, {48'h0, word_q});
		cmp_bit("all acks seen", 1'b1, exp_q.size() == 0);
	endtask

	// ----------------------------------------------------------------
	// Result watcher, clock, timeout, main sequence
	// ----------------------------------------------------------------
	always @(negedge clk_sys) begin
		if (instr_ack === 1'b1) begin
			if (exp_q.size() == 0) begin
				cmp_bit("instr_ack", 1'b0, instr_ack);
			end else begin
				mon_ex = exp_q.pop_front();
				cmp_bit("rung_q", mon_ex.rung, rung_q);
				cmp_vec("points_q", mon_ex.pts, points_q);
				cmp_bit("bcd_err_q", mon_ex.err, bcd_err_q);
			end
		end
	end

	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			stop_test();
		end
	end

	initial begin
		rst = 1'b1;
		scan_start = 1'b0;
		instr_valid = 1'b0;
		instr = '0;
		in_pins = 8'h00;
		word_sel = 8'h03;
		lfsr = 32'h3e9801b3;
		// Inverted rise keeps the pulse coil input high for several scans
		prog[0]  = mk(LCE_OP_RISE_START_CONTACT, 8'h00, 8'h00, 8'h00);
		prog[1]  = mk(LCE_OP_INVERT, 8'h00, 8'h00, 8'h00);
		prog[2]  = mk(LCE_OP_RISE_PULSE_COIL, 8'h14, 8'h00, 8'h00);
		prog[3]  = mk(LCE_OP_FALL_START_CONTACT, 8'h01, 8'h00, 8'h00);
		prog[4]  = mk(LCE_OP_RISE_PARALLEL_CONTACT, 8'h02, 8'h00, 8'h00);
		prog[5]  = mk(LCE_OP_FALL_SERIES_CONTACT, 8'h03, 8'h00, 8'h00);
		prog[6]  = mk(LCE_OP_OR_COIL, 8'h15, 8'h00, 8'h00);
		prog[7]  = mk(LCE_OP_RISE_START_CONTACT, 8'h05, 8'h00, 8'h00);
		prog[8]  = mk(LCE_OP_FALL_PARALLEL_CONTACT, 8'h06, 8'h00, 8'h00);
		prog[9]  = mk(LCE_OP_RISE_SERIES_CONTACT, 8'h07, 8'h00, 8'h00);
		prog[10] = mk(LCE_OP_OR_COIL, 8'h15, 8'h00, 8'h00);
		prog[11] = mk(LCE_OP_BIT_COIL, 8'h03, 8'hff, 8'h00);
		prog[12] = mk(LCE_OP_INVERT, 8'h00, 8'h00, 8'h00);
		prog[13] = mk(LCE_OP_BIT_COIL, 8'h03, 8'hff, 8'h00);
		prog[14] = mk(LCE_OP_SET, 8'h1e, 8'h00, 8'h03);
		prog[15] = mk(LCE_OP_SET, 8'h3e, 8'h00, 8'h04);
		prog[16] = mk(LCE_OP_FALL_START_CONTACT, 8'h04, 8'h00, 8'h00);
		prog[17] = mk(LCE_OP_RESET, 8'h1f, 8'h00, 8'h00);
		prog[18] = mk(LCE_OP_BIT_COIL, 8'h03, 8'h1a, 8'h00);
		prog[19] = mk(LCE_OP_BIT_COIL, 8'h03, 8'h16, 8'h00);
		prog[20] = mk(LCE_OP_BIT_COIL, 8'h03, 8'h15, 8'h00);
		do_reset();
		for (int s = 0; s < 24; s++) run_scan(s);
		$display("test first scan run done");
		do_reset();
		cmp_vec("points_q after reset", 64'h0, points_q);
		cmp_bit("rung_q after reset", 1'b0, rung_q);
		for (int s = 24; s < 40; s++) run_scan(s);
		$display("test scans after reset done");
		word_sel = 8'h14;
		repeat (3) @(negedge clk_sys);
		cmp_vec("word_q unmapped", 64'h0, {48'h0, word_q});
		$display("test unmapped word done");
		stop_test();
	end
endmodule
